// ---- light_curtain_indicators.sv ----
// Indicator lamps of transmitter and receiver, beam scan engine and APB register file.
// Assumes device logic reports its state synchronously to i_clk_sys and that beam
// receive levels arrive already sampled on the same clock.

module light_curtain_indicators
   import indicator_pkg::*;
#(
   parameter int unsigned NUM_BEAMS = 16,
   parameter int unsigned BEAM_CYC = BEAM_DWELL_CYC,
   parameter int unsigned SLOW_CYC = SLOW_HALF_CYC,
   parameter int unsigned FAST_CYC = FAST_HALF_CYC
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Device state.
   input wire logic i_tx_device_error,
   input wire rx_state_s i_rx_state,
   // Beam levels, bit 0 and the top bit are the coded sync beams.
   input wire logic [NUM_BEAMS-1:0] i_beam_clear,
   // Lamps.
   output bicolor_s o_tx_primary_indicator,
   output bicolor_s o_tx_secondary_indicator,
   output bicolor_s o_rx_primary_indicator,
   output logic o_rx_interlock_yellow,
   // Interrupt.
   output logic o_irq
);

   localparam int unsigned BEAM_IDX_W = $clog2(NUM_BEAMS);
   localparam int unsigned DWELL_W = $clog2(BEAM_CYC + 1);

   // Elaboration checks for parameters the logic cannot serve.
   if (NUM_BEAMS < 2) begin : g_bad_beams
      $error("light_curtain_indicators needs at least two beams");
   end
   if (BEAM_CYC < 1) begin : g_bad_dwell
      $error("light_curtain_indicators needs a beam dwell of one cycle or more");
   end
   if (FAST_CYC >= SLOW_CYC) begin : g_bad_rates
      $error("fast flash must be quicker than slow flash");
   end
   if (CTRL_W > 32 || IRQ_W > 32 || SCAN_CNT_W > 32) begin : g_bad_fields
      $error("register fields must fit the 32-bit data word");
   end

   // Register state.
   logic [CTRL_W-1:0] ctrl_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [SCAN_CNT_W-1:0] scan_cnt_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // Scan engine state.
   scan_state_e scan_state_reg;
   scan_state_e scan_state_next;
   logic [BEAM_IDX_W-1:0] beam_idx_reg;
   logic [DWELL_W-1:0] dwell_reg;
   logic all_clear_reg;
   logic sync_first_reg;
   logic sync_ok_reg;
   logic field_free_reg;

   // Lamp and edge-detect flip-flops.
   bicolor_s tx_pri_reg;
   bicolor_s tx_sec_reg;
   bicolor_s rx_pri_reg;
   logic yellow_reg;
   logic err_any_reg;
   bicolor_s tx_pri_next;
   bicolor_s tx_sec_next;
   bicolor_s rx_pri_next;
   logic yellow_next;

   // Flash phases.
   logic slow_phase;
   logic fast_phase;

   // Bus decode.
   logic setup_ph;
   logic wr_acc;
   logic hit_ctrl;
   logic hit_status;
   logic hit_irq_stat;
   logic hit_irq_mask;
   logic hit_scan_cnt;
   logic addr_hit;
   logic [31:0] rd_mux;
   logic [IRQ_W-1:0] w1c;
   logic [STAT_W-1:0] status_word;

   // Scan decode.
   logic dwell_end;
   logic last_beam;
   logic first_beam;
   logic beam_now;
   logic scan_end;
   logic sync_now;
   logic field_now;
   logic scan_en;
   logic chan2;
   logic reduced;
   logic ext_test;
   logic err_any;
   logic blocked;
   logic [IRQ_W-1:0] event_vec;

   // Both flash generators; 1 Hz and 10 Hz with equal halves.
   blink_gen #(.HALF_CYC(SLOW_CYC)) u_slow_blink (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .o_phase(slow_phase)
   );
   blink_gen #(.HALF_CYC(FAST_CYC)) u_fast_blink (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .o_phase(fast_phase)
   );

   // APB address decode; every access completes with no wait state.
   assign setup_ph = i_psel & ~i_penable;
   assign wr_acc = i_psel & i_penable & i_pwrite;
   assign hit_ctrl = (i_paddr == ADDR_CTRL);
   assign hit_status = (i_paddr == ADDR_STATUS);
   assign hit_irq_stat = (i_paddr == ADDR_IRQ_STAT);
   assign hit_irq_mask = (i_paddr == ADDR_IRQ_MASK);
   assign hit_scan_cnt = (i_paddr == ADDR_SCAN_CNT);
   assign addr_hit = hit_ctrl | hit_status | hit_irq_stat | hit_irq_mask | hit_scan_cnt;
   assign w1c = (wr_acc & hit_irq_stat) ? i_pwdata[IRQ_W-1:0] : '0;
   assign o_pready = 1'b1;
   assign o_pslverr = pslverr_reg & i_psel & i_penable;
   assign o_prdata = prdata_reg;

   // Status word built by field position, so the layout lives in one place.
   assign status_word[STAT_SYNC_OK] = sync_ok_reg;
   assign status_word[STAT_FIELD_FREE] = field_free_reg;
   // The output state is read live; it is not tied to a scan boundary.
   assign status_word[STAT_OUTPUTS_ON] = i_rx_state.safety_switching_outputs_on;

   // Read data selection; unused bits read as zero.
   assign rd_mux = hit_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl_reg} :
                   hit_status ? {{(32 - STAT_W){1'b0}}, status_word} :
                   hit_irq_stat ? {{(32 - IRQ_W){1'b0}}, irq_stat_reg} :
                   hit_irq_mask ? {{(32 - IRQ_W){1'b0}}, irq_mask_reg} :
                   hit_scan_cnt ? {{(32 - SCAN_CNT_W){1'b0}}, scan_cnt_reg} :
                   32'h0000_0000;

   // Read data and error flag are set up in the setup cycle so they stand in access.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup_ph) begin
         prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_reg <= ~addr_hit;
      end
   end

   // Control and mask take effect at the access edge only.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_reg <= CTRL_RESET;
         irq_mask_reg <= IRQ_MASK_RESET;
      end else if (wr_acc) begin
         if (hit_ctrl) ctrl_reg <= i_pwdata[CTRL_W-1:0];
         if (hit_irq_mask) irq_mask_reg <= i_pwdata[IRQ_W-1:0];
      end
   end

   // Control fields unpacked once so the lamp and scan logic read named bits.
   assign scan_en = ctrl_reg[CTRL_SCAN_EN];
   assign chan2 = ctrl_reg[CTRL_CHAN2];
   assign reduced = ctrl_reg[CTRL_REDUCED];
   assign ext_test = ctrl_reg[CTRL_EXT_TEST];

   // Beam walk: each beam is held BEAM_CYC cycles, first to last.
   assign dwell_end = (dwell_reg == DWELL_W'(BEAM_CYC - 1));
   assign first_beam = (beam_idx_reg == '0);
   assign last_beam = (beam_idx_reg == BEAM_IDX_W'(NUM_BEAMS - 1));
   assign beam_now = i_beam_clear[beam_idx_reg];
   assign scan_end = (scan_state_reg == SCAN_RUN) & dwell_end & last_beam;
   // Either coded beam alone keeps the pair synchronised.
   assign sync_now = sync_first_reg | beam_now;
   // Without synchronisation there is no valid protective field.
   assign field_now = all_clear_reg & beam_now & sync_now;

   // Scan state transition.
   always_comb begin
      scan_state_next = scan_state_reg;
      unique case (scan_state_reg)
         SCAN_IDLE: begin
            if (scan_en) scan_state_next = SCAN_RUN;
         end
         SCAN_RUN: begin
            if (!scan_en && scan_end) scan_state_next = SCAN_IDLE;
         end
      endcase
   end

   // Beam index and dwell counters run only inside a scan.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scan_state_reg <= SCAN_IDLE;
         beam_idx_reg <= '0;
         dwell_reg <= '0;
      end else begin
         scan_state_reg <= scan_state_next;
         if (scan_state_reg != SCAN_RUN) begin
            beam_idx_reg <= '0;
            dwell_reg <= '0;
         end else if (dwell_end) begin
            dwell_reg <= '0;
            beam_idx_reg <= last_beam ? '0 : beam_idx_reg + 1'b1;
         end else begin
            dwell_reg <= dwell_reg + 1'b1;
         end
      end
   end

   // Per-scan accumulation; results update once per completed scan.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         all_clear_reg <= 1'b1;
         sync_first_reg <= 1'b0;
         sync_ok_reg <= 1'b0;
         field_free_reg <= 1'b0;
         scan_cnt_reg <= '0;
      end else if ((scan_state_reg == SCAN_RUN) && dwell_end) begin
         if (last_beam) begin
            all_clear_reg <= 1'b1;
            sync_ok_reg <= sync_now;
            field_free_reg <= field_now;
            scan_cnt_reg <= scan_cnt_reg + 1'b1;
         end else begin
            all_clear_reg <= all_clear_reg & beam_now;
            if (first_beam) sync_first_reg <= beam_now;
         end
      end
   end

   // Events that feed the sticky interrupt status.
   assign err_any = i_tx_device_error | i_rx_state.int_error | i_rx_state.ext_error;
   assign event_vec[IRQ_SCAN_DONE] = scan_end;
   assign event_vec[IRQ_SYNC_LOST] = scan_end & sync_ok_reg & ~sync_now;
   assign event_vec[IRQ_FIELD_BREAK] = scan_end & field_free_reg & ~field_now;
   assign event_vec[IRQ_ERROR] = err_any & ~err_any_reg;

   // Previous error level for the edge detector; it resets low like its idle inputs.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) err_any_reg <= 1'b0;
      else err_any_reg <= err_any;
   end

   // Sticky status bits; a new event wins over a write-one-to-clear in the same cycle.
   for (genvar gi = 0; gi < IRQ_W; gi++) begin : g_irq
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
         if (!i_rst_b) irq_stat_reg[gi] <= 1'b0;
         else irq_stat_reg[gi] <= event_vec[gi] | (irq_stat_reg[gi] & ~w1c[gi]);
      end
   end

   assign o_irq = |(irq_stat_reg & irq_mask_reg);

   // Transmitter lamps; error first, then test, then range, then normal.
   always_comb begin
      tx_pri_next = '{red: 1'b0, green: 1'b1};
      tx_sec_next = '{red: 1'b0, green: chan2};
      if (i_tx_device_error) begin
         tx_pri_next = '{red: 1'b1, green: 1'b0};
         tx_sec_next = '{red: 1'b0, green: 1'b0};
      end else if (ext_test) begin
         tx_pri_next = '{red: 1'b0, green: 1'b1};
         tx_sec_next = '{red: slow_phase, green: 1'b0};
      end else if (reduced) begin
         tx_pri_next = '{red: 1'b0, green: slow_phase};
         tx_sec_next = '{red: 1'b0, green: chan2 & slow_phase};
      end
   end

   // Receiver primary lamp; internal error outranks external, then output state.
   always_comb begin
      if (i_rx_state.int_error) begin
         rx_pri_next = '{red: fast_phase, green: 1'b0};
      end else if (i_rx_state.ext_error) begin
         rx_pri_next = '{red: slow_phase, green: 1'b0};
      end else if (!i_rx_state.safety_switching_outputs_on) begin
         rx_pri_next = '{red: 1'b1, green: 1'b0};
      end else if (i_rx_state.weak_signal) begin
         rx_pri_next = '{red: 1'b0, green: slow_phase};
      end else begin
         rx_pri_next = '{red: 1'b0, green: 1'b1};
      end
   end

   // Yellow lamp lights only when blocked with a clear field, ready to unlock.
   assign blocked = i_rx_state.interlock_en & ~i_rx_state.interlock_released;
   assign yellow_next = blocked & field_free_reg;

   // Lamps leave through flip-flops so no decode glitch reaches a driver.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_pri_reg <= '0;
         tx_sec_reg <= '0;
         rx_pri_reg <= '0;
         yellow_reg <= 1'b0;
      end else begin
         tx_pri_reg <= tx_pri_next;
         tx_sec_reg <= tx_sec_next;
         rx_pri_reg <= rx_pri_next;
         yellow_reg <= yellow_next;
      end
   end

   assign o_tx_primary_indicator = tx_pri_reg;
   assign o_tx_secondary_indicator = tx_sec_reg;
   assign o_rx_primary_indicator = rx_pri_reg;
   assign o_rx_interlock_yellow = yellow_reg;

endmodule : light_curtain_indicators

// ---- indicator_blink.sv ----
// Shared constants, carriers and the flash-phase generator for the indicator block.
// Assumes one free-running 125 MHz clock and an active-low asynchronous reset.

package indicator_pkg;

   // Clock period, flash half periods and beam dwell, every time in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SLOW_HALF_NS = 500_000_000;
   localparam int unsigned FAST_HALF_NS = 50_000_000;
   localparam int unsigned BEAM_DWELL_NS = 80;
   // Cycle counts derived from the times; all divide exactly at 8 ns.
   localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned BEAM_DWELL_CYC = (BEAM_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register byte addresses on the APB port.
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_SCAN_CNT = 8'h10;

   // Control register fields and reset value.
   localparam int unsigned CTRL_W = 4;
   localparam int unsigned CTRL_SCAN_EN = 0;
   localparam int unsigned CTRL_CHAN2 = 1;
   localparam int unsigned CTRL_REDUCED = 2;
   localparam int unsigned CTRL_EXT_TEST = 3;
   localparam logic [3:0] CTRL_RESET = 4'h1;

   // Status register fields.
   localparam int unsigned STAT_W = 3;
   localparam int unsigned STAT_SYNC_OK = 0;
   localparam int unsigned STAT_FIELD_FREE = 1;
   localparam int unsigned STAT_OUTPUTS_ON = 2;

   // Interrupt status and mask fields, one bit per event.
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_SCAN_DONE = 0;
   localparam int unsigned IRQ_SYNC_LOST = 1;
   localparam int unsigned IRQ_FIELD_BREAK = 2;
   localparam int unsigned IRQ_ERROR = 3;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   localparam int unsigned SCAN_CNT_W = 16;

   // One two-colour lamp.
   typedef struct packed {
      logic red;
      logic green;
   } bicolor_s;

   // Receiver-side state reported by the surrounding device logic.
   typedef struct packed {
      logic safety_switching_outputs_on;
      logic weak_signal;
      logic ext_error;
      logic int_error;
      logic interlock_en;
      logic interlock_released;
   } rx_state_s;

   typedef enum logic [0:0] {
      SCAN_IDLE = 1'b0,
      SCAN_RUN = 1'b1
   } scan_state_e;

endpackage : indicator_pkg

// Square-wave phase with equal high and low halves of HALF_CYC cycles each.
module blink_gen #(
   parameter int unsigned HALF_CYC = 4
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Flash phase, high during the lit half.
   output logic o_phase
);
   localparam int unsigned CNT_W = $clog2(HALF_CYC + 1);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic phase_reg;
   logic half_end;

   if (HALF_CYC < 1) begin : g_bad_half
      $error("blink_gen needs HALF_CYC of at least one");
   end

   // Wrap at the end of each half and flip the phase there.
   assign half_end = (cnt_reg == CNT_W'(HALF_CYC - 1));
   assign cnt_next = half_end ? '0 : cnt_reg + 1'b1;
   assign o_phase = phase_reg;

   // Counter and phase flip-flops.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_reg <= '0;
         phase_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         phase_reg <= phase_reg ^ half_end;
      end
   end

endmodule : blink_gen

// ---- beam_field.sv ----
// Optical counterpart model: presents the receiver with a pattern of clear beams.
// Assumes the bench selects the pattern between scans; levels are already clock-sampled.
module beam_field #(
   parameter int unsigned NUM_BEAMS = 4
) (
   // Pattern select: 0 clear, 1 first sync beam blocked, 2 both blocked, 3 inner beam blocked.
   input wire logic [1:0] i_mode,
   // Beam levels towards the receiver, 1 means unobstructed.
   output logic [NUM_BEAMS-1:0] o_beam_clear
);
   // The sync beams sit at both ends; an inner beam is only a field beam.
   logic [NUM_BEAMS-1:0] block_mask;
   assign block_mask = (i_mode == 2'h1) ? NUM_BEAMS'(1) :
      (i_mode == 2'h2) ? (NUM_BEAMS'(1) | (NUM_BEAMS'(1) << (NUM_BEAMS - 1))) :
      (i_mode == 2'h3) ? NUM_BEAMS'(2) : '0;
   assign o_beam_clear = ~block_mask;
endmodule : beam_field

// ---- lci_chk.sv ----
// Port-level checker for the indicator block.
// Assumes it is bound into light_curtain_indicators with the same flash parameters.
module lci_chk
   import indicator_pkg::*;
#(
   parameter int unsigned SLOW_CYC = 20,
   parameter int unsigned FAST_CYC = 4
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Bus and device state.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic i_tx_device_error,
   input wire rx_state_s i_rx_state,
   // Lamps.
   input wire bicolor_s o_tx_primary_indicator,
   input wire bicolor_s o_tx_secondary_indicator,
   input wire bicolor_s o_rx_primary_indicator,
   input wire logic o_rx_interlock_yellow
);
   localparam int unsigned FAST_HOLD = 2 * FAST_CYC + 3;
   localparam int unsigned SLOW_HOLD = 2 * SLOW_CYC + 3;
   logic [1:0] warm_reg;
   logic [6:0] int_hold_reg;
   logic [6:0] ext_hold_reg;
   logic [6:0] run_reg;
   logic red_reg;
   wire logic mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS) ||
      (i_paddr == ADDR_IRQ_STAT) || (i_paddr == ADDR_IRQ_MASK) || (i_paddr == ADDR_SCAN_CNT);

   // Lamps lag inputs by one cycle, so checking waits two edges after reset.
   // Hold counters saturate; flash checks need half periods of at most 62 cycles.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         warm_reg <= 2'h0;
         int_hold_reg <= 7'h00;
         ext_hold_reg <= 7'h00;
         run_reg <= 7'h00;
         red_reg <= 1'b0;
      end else begin
         warm_reg <= {warm_reg[0], 1'b1};
         int_hold_reg <= !i_rx_state.int_error ? 7'h00 : int_hold_reg + (int_hold_reg != 7'h7F);
         ext_hold_reg <= (!i_rx_state.ext_error || i_rx_state.int_error) ? 7'h00 :
            ext_hold_reg + (ext_hold_reg != 7'h7F);
         red_reg <= o_rx_primary_indicator.red;
         run_reg <= (o_rx_primary_indicator.red != red_reg) ? 7'h01 :
            run_reg + (run_reg != 7'h7F);
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b || !warm_reg[1]);

   // A red edge once the error has held long enough to fill a whole run.
   sequence s_fast_edge;
      (int_hold_reg >= FAST_HOLD) ##0 $changed(o_rx_primary_indicator.red);
   endsequence
   sequence s_slow_edge;
      (ext_hold_reg >= SLOW_HOLD) ##0 $changed(o_rx_primary_indicator.red);
   endsequence

   a_tx_error_red: assert property (i_tx_device_error |=>
      (o_tx_primary_indicator == 2'h2) && (o_tx_secondary_indicator == 2'h0))
      else $error("tx error lamps wrong");
   a_tx_normal_nored: assert property (!i_tx_device_error |=>
      !o_tx_primary_indicator.red) else $error("tx red without error");
   a_rx_fast_half: assert property (s_fast_edge |-> run_reg == FAST_CYC)
      else $error("fast flash half period wrong");
   a_rx_slow_half: assert property (s_slow_edge |-> run_reg == SLOW_CYC)
      else $error("slow flash half period wrong");
   a_rx_error_nogreen: assert property ((i_rx_state.int_error || i_rx_state.ext_error) |=>
      !o_rx_primary_indicator.green) else $error("green shown during error");
   a_rx_off_red: assert property ((!i_rx_state.safety_switching_outputs_on &&
      !i_rx_state.int_error && !i_rx_state.ext_error) |=> o_rx_primary_indicator == 2'h2)
      else $error("outputs off not red");
   a_rx_on_green: assert property ((i_rx_state.safety_switching_outputs_on &&
      !i_rx_state.weak_signal && !i_rx_state.int_error && !i_rx_state.ext_error) |=>
      o_rx_primary_indicator == 2'h1) else $error("outputs on not green");
   a_yellow_dark: assert property ((!i_rx_state.interlock_en ||
      i_rx_state.interlock_released) |=> !o_rx_interlock_yellow) else $error("yellow lit");
   a_yellow_blocked: assert property (o_rx_interlock_yellow |->
      $past(i_rx_state.interlock_en) && !$past(i_rx_state.interlock_released))
      else $error("yellow without blocked interlock");
   a_bus_unmapped: assert property (i_psel && i_penable |->
      (o_pslverr == !mapped) && (mapped || o_prdata == 32'h0)) else $error("bus error flag wrong");
endmodule : lci_chk

// ---- tb_light_curtain_indicators.sv ----
// Self-checking bench for the indicator block with a beam pattern model.
// Assumes short flash and scan parameters; the checker is bound at the foot.
module tb_light_curtain_indicators
   import indicator_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned NB = 4;
   localparam int unsigned BC = 2;
   localparam int unsigned SLOW = 20;
   localparam int unsigned FAST = 4;
   localparam int unsigned SCAN = NB * BC;
   logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, tx_err, yellow, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] mode;
   logic [NB-1:0] beam;
   rx_state_s rx;
   bicolor_s tx_pri, tx_sec, rx_pri;
   int failures, samples_checked;

   beam_field #(.NUM_BEAMS(NB)) i_beam_field (.i_mode(mode), .o_beam_clear(beam));
   light_curtain_indicators #(.NUM_BEAMS(NB), .BEAM_CYC(BC), .SLOW_CYC(SLOW), .FAST_CYC(FAST))
   i_light_curtain_indicators (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tx_device_error(tx_err),
      .i_rx_state(rx), .i_beam_clear(beam), .o_tx_primary_indicator(tx_pri),
      .o_tx_secondary_indicator(tx_sec), .o_rx_primary_indicator(rx_pri),
      .o_rx_interlock_yellow(yellow), .o_irq(irq));

   // Free-running 125 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish();
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One APB transfer; a clock edge passes after release so calls never collide.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clk_sys);
      penable <= 1'b1;
      // No limit of its own: only the watchdog ends a wait that never answers.
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] q;
      logic e;
      apb(1'b1, addr, data, q, e);
   endtask : wr

   task automatic rd(input logic [7:0] addr, output logic [31:0] q, output logic e);
      apb(1'b0, addr, 32'h0, q, e);
   endtask : rd

   // Counts lit cycles per lamp over two slow periods; digit 0 dark, 1 flashing, 2 steady.
   task automatic observe(input string code);
      int cnt [7];
      logic [6:0] lamps;
      foreach (cnt[i]) cnt[i] = 0;
      // Lamps are sampled at the falling edge, where the registered outputs have settled.
      repeat (4 * SLOW) begin
         @(negedge clk_sys);
         lamps = {tx_pri, tx_sec, rx_pri, yellow};
         foreach (cnt[i]) cnt[i] += (lamps[i] === 1'b1);
      end
      @(posedge clk_sys);
      foreach (cnt[i]) check(cnt[i], 2 * SLOW * (int'(code[6-i]) - 48));
   endtask : observe

   task automatic cfg(input logic [3:0] ctrl, input logic err, input rx_state_s rx_v);
      wr(ADDR_CTRL, {28'h0, ctrl});
      tx_err <= err;
      rx <= rx_v;
      repeat (3) @(posedge clk_sys);
   endtask : cfg

   task automatic t_regs();
      logic [31:0] q;
      logic e;
      rd(ADDR_CTRL, q, e);
      check(q, 32'h1);
      rd(ADDR_IRQ_MASK, q, e);
      check(q, 32'h0);
      rd(8'h14, q, e);
      check(q, 32'h0);
      check(e, 1'b1);
   endtask : t_regs

   // Reads are spaced by whole scans, so the count must move by exactly five.
   task automatic t_scan();
      logic [31:0] a, b;
      logic e;
      rd(ADDR_SCAN_CNT, a, e);
      repeat (5 * SCAN - 3) @(posedge clk_sys);
      rd(ADDR_SCAN_CNT, b, e);
      check((b - a) & 32'hFFFF, 32'h5);
      wr(ADDR_CTRL, 32'h0);
      repeat (2 * SCAN) @(posedge clk_sys);
      rd(ADDR_SCAN_CNT, a, e);
      repeat (3 * SCAN) @(posedge clk_sys);
      rd(ADDR_SCAN_CNT, b, e);
      check(b, a);
   endtask : t_scan

   task automatic t_irq();
      logic [31:0] q;
      logic e;
      cfg(4'h1, 1'b0, 6'h20);
      wr(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_IRQ_STAT, 32'hF);
      repeat (2 * SCAN) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT, q, e);
      check(q, 32'h1);
      check(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h1);
      check(irq, 1'b1);
      wr(ADDR_CTRL, 32'h0);
      repeat (2 * SCAN) @(posedge clk_sys);
      wr(ADDR_IRQ_STAT, 32'h1);
      rd(ADDR_IRQ_STAT, q, e);
      check(q, 32'h0);
      check(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h8);
      tx_err <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT, q, e);
      check(q, 32'h8);
      check(irq, 1'b1);
      tx_err <= 1'b0;
      wr(ADDR_IRQ_STAT, 32'h8);
      check(irq, 1'b0);
   endtask : t_irq

   // Loss events are cleared while the pattern is still settled, then the new one is shown.
   task automatic t_beam(input logic [1:0] m, input rx_state_s rx_v, input string y,
      input logic [31:0] status, input logic [1:0] lost);
      logic [31:0] q;
      logic e;
      wr(ADDR_IRQ_STAT, 32'h6);
      mode <= m;
      cfg(4'h1, 1'b0, rx_v);
      repeat (3 * SCAN) @(posedge clk_sys);
      rd(ADDR_STATUS, q, e);
      check(q, status);
      rd(ADDR_IRQ_STAT, q, e);
      check(q & 32'h6, {29'h0, lost, 1'b0});
      observe({"020002", y});
   endtask : t_beam

   // Main sequence: reset, registers, scans, lamps, interrupts, beam patterns.
   initial begin
      rst_b = 1'b0;
      {psel, penable, pwrite, tx_err} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      mode = 2'h0;
      rx = 6'h00;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_scan();
      cfg(4'h1, 1'b0, 6'h00);
      observe("0200200");
      cfg(4'h3, 1'b0, 6'h00);
      observe("0202200");
      cfg(4'h5, 1'b0, 6'h00);
      observe("0100200");
      cfg(4'h7, 1'b0, 6'h00);
      observe("0101200");
      cfg(4'h9, 1'b0, 6'h00);
      observe("0210200");
      cfg(4'hB, 1'b1, 6'h00);
      observe("2000200");
      cfg(4'h1, 1'b0, 6'h24);
      observe("0200100");
      cfg(4'h1, 1'b0, 6'h28);
      observe("0200100");
      cfg(4'h1, 1'b0, 6'h30);
      observe("0200010");
      cfg(4'h1, 1'b0, 6'h20);
      observe("0200020");
      cfg(4'h1, 1'b0, 6'h2C);
      observe("0200100");
      t_irq();
      t_beam(2'h0, 6'h22, "2", 32'h7, 2'h0);
      t_beam(2'h1, 6'h22, "0", 32'h5, 2'h2);
      t_beam(2'h3, 6'h22, "0", 32'h5, 2'h0);
      t_beam(2'h2, 6'h22, "0", 32'h4, 2'h1);
      t_beam(2'h0, 6'h23, "0", 32'h7, 2'h0);
      t_beam(2'h0, 6'h20, "0", 32'h7, 2'h0);
      tally_and_finish();
   end

   // The run needs under two thousand cycles; this span leaves ample margin.
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end
endmodule : tb_light_curtain_indicators

bind light_curtain_indicators lci_chk #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) i_lci_chk (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
   .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
   .i_tx_device_error(i_tx_device_error), .i_rx_state(i_rx_state),
   .o_tx_primary_indicator(o_tx_primary_indicator),
   .o_tx_secondary_indicator(o_tx_secondary_indicator),
   .o_rx_primary_indicator(o_rx_primary_indicator), .o_rx_interlock_yellow(o_rx_interlock_yellow));
